// *** rtl/tpsr_pkg.sv ***
// package of offsets, fields and reset values for the test and self-check register group
`default_nettype none
package tpsr_pkg;
   // ----------------------------------------------------------------
   // register byte addresses (printed offsets are not all word aligned: index x4)
   // ----------------------------------------------------------------
   localparam logic [7:0] TPSR_IDX_PIN_LEVEL = 8'h34;
   localparam logic [7:0] TPSR_IDX_PROBE_BUS = 8'h35;
   localparam logic [7:0] TPSR_IDX_SELF_CHECK = 8'h36;
   localparam logic [7:0] TPSR_IDX_VERSION = 8'h37;
   localparam logic [9:0] TPSR_ADDR_PIN_LEVEL = {TPSR_IDX_PIN_LEVEL, 2'b00};
   localparam logic [9:0] TPSR_ADDR_PROBE_BUS = {TPSR_IDX_PROBE_BUS, 2'b00};
   localparam logic [9:0] TPSR_ADDR_SELF_CHECK = {TPSR_IDX_SELF_CHECK, 2'b00};
   localparam logic [9:0] TPSR_ADDR_VERSION = {TPSR_IDX_VERSION, 2'b00};
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int TPSR_IO_SELECT_BIT = 7;
   localparam int TPSR_NONLINEAR_BIT = 6;
   localparam logic [7:0] TPSR_PIN_LEVEL_RST = 8'h00;
   localparam logic [7:0] TPSR_SELF_CHECK_RST = 8'h40;
   localparam logic [3:0] TPSR_SELF_TEST_ON = 4'h9;
   localparam logic [3:0] TPSR_SELF_TEST_OFF = 4'h0;
   localparam logic [7:0] TPSR_PIN_LEVEL_WMASK = 8'hfe;
   localparam logic [7:0] TPSR_SELF_CHECK_WMASK = 8'h4f;
   // arbitrary neutral version code, not taken from any part
   localparam logic [7:0] TPSR_VERSION_CODE = 8'h5a;
   localparam int TPSR_NUM_PINS = 7;
   typedef enum logic [1:0] {TPSR_IDLE, TPSR_DATA} tpsr_phase_e;
endpackage
`default_nettype wire

// *** rtl/tpsr_ctl_if.sv ***
// interface carrying register-write strobes from the bus slave to the register core
`default_nettype none
interface tpsr_ctl_if;
   logic wr_pin_level;
   logic wr_self_check;
   logic [7:0] wdata;
   logic [9:0] addr;
   logic [7:0] rdata;
   modport slave (output wr_pin_level, output wr_self_check, output wdata, output addr,
      input rdata);
   modport core (input wr_pin_level, input wr_self_check, input wdata, input addr,
      output rdata);
endinterface
`default_nettype wire

// *** rtl/tpsr_ahb_slave.sv ***
// AHB-Lite slave front end: address-phase capture and write strobes
`default_nettype none
module tpsr_ahb_slave
   import tpsr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   tpsr_ctl_if.slave ctl
);
   tpsr_phase_e phase_q;
   tpsr_phase_e phase_d;
   logic wr_q;
   logic [9:0] addr_q;
   logic [31:0] hrdata_q;
   wire take = hsel && hready && htrans[1];
   wire wr_now = (phase_q == TPSR_DATA) && wr_q;
   wire rd_take = take && !hwrite;

   assign phase_d = take ? TPSR_DATA : TPSR_IDLE;
   // read decode looks at the address phase so the data phase carries the answer
   assign ctl.addr = take ? haddr[9:0] : addr_q;
   assign ctl.wdata = hwdata[7:0];
   assign ctl.wr_pin_level = wr_now && (addr_q == TPSR_ADDR_PIN_LEVEL);
   assign ctl.wr_self_check = wr_now && (addr_q == TPSR_ADDR_SELF_CHECK);
   assign hrdata = hrdata_q;

   // read data is captured at the address-phase edge so it stands through the
   // whole data phase with zero wait states; a read right behind a write to the
   // same register sees the old value
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= TPSR_IDLE;
         wr_q <= 1'b0;
         addr_q <= 10'h000;
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         phase_q <= phase_d;
         if (take)
         begin
            wr_q <= hwrite;
            addr_q <= haddr[9:0];
         end
         hrdata_q <= rd_take ? {24'h000000, ctl.rdata} : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// *** rtl/tpsr_top.sv ***
// test port, probe bus view, self-check control and version registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
module tpsr_top
   import tpsr_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   input wire logic [7:0] PIN_ENABLE_REGISTER,
   input wire logic [7:0] PROBE_BUS,
   input wire logic SELF_TEST_CMD,
   input wire logic [6:0] TEST_PORT_PINS_IN,
   output logic [6:0] TEST_PORT_PINS_OUT,
   output logic [6:0] TEST_PORT_PINS_OE,
   output logic RECEIVER_NONLINEAR,
   output logic THRESHOLD_NONLINEAR,
   output logic SELF_TEST_ENABLED,
   output logic SELF_TEST_RUN
);
   tpsr_ctl_if ctl ();
   logic [7:0] pin_level_q;
   logic [7:0] self_check_q;
   logic [6:0] pins_out_q;
   logic [6:0] pins_oe_q;
   logic nonlin_q;
   logic st_en_q;
   logic st_run_q;
   logic [31:0] hrdata_w;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   tpsr_ahb_slave u_slave (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .hsel(HSEL),
      .haddr(HADDR),
      .htrans(HTRANS),
      .hwrite(HWRITE),
      .hwdata(HWDATA),
      .hready(HREADY),
      .hrdata(hrdata_w),
      .ctl(ctl.slave)
   );

   // ----------------------------------------------------------------
   // decode and read mux
   // ----------------------------------------------------------------
   wire io_mode = pin_level_q[TPSR_IO_SELECT_BIT];
   // io mode shows live pins 5..0 in bits 6..1; bit 0 is reserved and reads zero
   wire [7:0] pin_read = io_mode ? {pin_level_q[7], TEST_PORT_PINS_IN[5:0], 1'b0}
                                 : pin_level_q;
   wire [7:0] pin_level_d = (ctl.wdata & TPSR_PIN_LEVEL_WMASK);
   wire [7:0] self_check_d = (ctl.wdata & TPSR_SELF_CHECK_WMASK);
   wire st_field_on = (self_check_q[3:0] == TPSR_SELF_TEST_ON);
   wire [7:0] drive_en = {1'b0, PIN_ENABLE_REGISTER[6:1], 1'b0};
   wire [7:0] rd_mux;
   assign rd_mux = (ctl.addr == TPSR_ADDR_PIN_LEVEL) ? pin_read :
                   (ctl.addr == TPSR_ADDR_PROBE_BUS) ? PROBE_BUS :
                   (ctl.addr == TPSR_ADDR_SELF_CHECK) ? self_check_q :
                   (ctl.addr == TPSR_ADDR_VERSION) ? TPSR_VERSION_CODE :
                   8'h00;
   assign ctl.rdata = rd_mux;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pin_level_q <= TPSR_PIN_LEVEL_RST;
         self_check_q <= TPSR_SELF_CHECK_RST;
      end
      else
      begin
         if (ctl.wr_pin_level)
            pin_level_q <= pin_level_d;
         if (ctl.wr_self_check)
            self_check_q <= self_check_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drive and control outputs, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pins_out_q <= 7'h00;
         pins_oe_q <= 7'h00;
         nonlin_q <= 1'b0;
         st_en_q <= 1'b0;
         st_run_q <= 1'b0;
      end
      else
      begin
         pins_out_q <= pin_level_q[7:1];
         pins_oe_q <= io_mode ? drive_en[7:1] : 7'h00;
         nonlin_q <= self_check_q[TPSR_NONLINEAR_BIT];
         st_en_q <= st_field_on;
         // command only honoured while the field holds the enable code
         st_run_q <= SELF_TEST_CMD && st_field_on;
      end
   end

   assign TEST_PORT_PINS_OUT = pins_out_q;
   assign TEST_PORT_PINS_OE = pins_oe_q;
   assign RECEIVER_NONLINEAR = nonlin_q;
   assign THRESHOLD_NONLINEAR = nonlin_q;
   assign SELF_TEST_ENABLED = st_en_q;
   assign SELF_TEST_RUN = st_run_q;
   assign HRDATA = hrdata_w;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
endmodule
`default_nettype wire

// *** dv/tpsr_properties.sv ***
// checker of bus, pin and self-check behaviour at the top ports
`default_nettype none
module tpsr_properties
   import tpsr_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [31:0] HRDATA,
   input wire logic [7:0] PIN_ENABLE_REGISTER,
   input wire logic SELF_TEST_CMD,
   input wire logic [6:0] TEST_PORT_PINS_OUT,
   input wire logic [6:0] TEST_PORT_PINS_OE,
   input wire logic RECEIVER_NONLINEAR,
   input wire logic THRESHOLD_NONLINEAR,
   input wire logic SELF_TEST_ENABLED,
   input wire logic SELF_TEST_RUN
);
   // the single slave's ready is the bus ready
   wire logic take = HSEL && HREADYOUT && HTRANS[1];
   wire logic wr_take = take && HWRITE;
   wire logic rd_take = take && !HWRITE;
   logic [7:0] pe_q;
   logic [6:0] wd_q;
   always_ff @(posedge REF_CLK)
   begin
      pe_q <= PIN_ENABLE_REGISTER;
      wd_q <= HWDATA[7:1];
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // ------------------------------
   // properties
   // ------------------------------
   chk_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not okay");
   chk_rdata_cause: assert property (HRDATA != 32'h0 |-> $past(rd_take))
      else $error("read data without a read");
   chk_version_read: assert property (
      rd_take && HADDR[9:0] == TPSR_ADDR_VERSION |-> ##1 HRDATA == {24'h0, TPSR_VERSION_CODE})
      else $error("version code wrong");
   chk_run_cause: assert property (SELF_TEST_RUN |-> $past(SELF_TEST_CMD) &&
      (SELF_TEST_ENABLED || $past(SELF_TEST_ENABLED))) else $error("self test run unqualified");
   chk_nonlin_pair: assert property (RECEIVER_NONLINEAR == THRESHOLD_NONLINEAR)
      else $error("threshold mode differs");
   chk_oe_enable: assert property ((TEST_PORT_PINS_OE & ~{1'b0, pe_q[6:1]}) == 7'h0)
      else $error("pin driven without enable");
   chk_pin_drive: assert property (
      wr_take && HADDR[9:0] == TPSR_ADDR_PIN_LEVEL |-> ##3 TEST_PORT_PINS_OUT == $past(wd_q))
      else $error("pin level not driven");
   chk_enable_cause: assert property ($changed(SELF_TEST_ENABLED) |->
      $past(wr_take && HADDR[9:0] == TPSR_ADDR_SELF_CHECK, 2) ||
      $past(wr_take && HADDR[9:0] == TPSR_ADDR_SELF_CHECK, 3)) else $error("enable moved alone");
   cover property (rd_take && HADDR[9:0] == TPSR_ADDR_VERSION);
   cover property (SELF_TEST_RUN);
   cover property (|TEST_PORT_PINS_OE);
endmodule
bind tpsr_top tpsr_properties tpsr_properties_inst (.*);
`default_nettype wire

// *** dv/tpsr_tb_top.sv ***
// random and corner-case bench for the test and self-check registers
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tpsr_tb_top import tpsr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK = 0, RST_N = 0, HSEL = 1, HWRITE = 0, SELF_TEST_CMD = 0;
   logic [31:0] HADDR = 0, HWDATA = 0, r, seed = 32'd65030;
   logic [1:0] HTRANS = 0;
   logic [2:0] HSIZE = 3'b010;
   logic [7:0] PIN_ENABLE_REGISTER = 0, PROBE_BUS = 0, d, s, q;
   logic [6:0] TEST_PORT_PINS_IN = 0;
   wire logic HREADYOUT, HRESP, RECEIVER_NONLINEAR, THRESHOLD_NONLINEAR;
   wire logic SELF_TEST_ENABLED, SELF_TEST_RUN;
   wire logic [31:0] HRDATA;
   wire logic [6:0] TEST_PORT_PINS_OUT, TEST_PORT_PINS_OE;
   wire logic HREADY = HREADYOUT;
   int bad_count = 0, checks = 0, cyc = 0;
   tpsr_top tpsr_top_inst (.*);
   always #4 REF_CLK = ~REF_CLK;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] wd);
      HADDR <= {22'h0, a};
      HWRITE <= w;
      HTRANS <= 2'b10;
      do @(posedge REF_CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= {24'h0, wd};
      do @(posedge REF_CLK); while (HREADY !== 1'b1);
      // taken at the edge that ends the data phase, before the slave moves on
      q = HRDATA[7:0];
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge REF_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         bad_count++;
         test_done();
      end
   end
   initial
   begin
      repeat (5) @(posedge REF_CLK);
      RST_N <= 1'b1;
      xfer(0, TPSR_ADDR_PIN_LEVEL, 0);
      `CHK("pin_level", 8'h00, q)
      xfer(0, TPSR_ADDR_SELF_CHECK, 0);
      `CHK("self_check", 8'h40, q)
      for (int i = 0; i < 12; i++)
      begin
         r = rnd();
         // odd passes force io mode and the enabling code
         d = {r[31] | i[0], r[30:24]};
         s = i[0] ? {r[7:4], 4'h9} : r[31:24];
         PIN_ENABLE_REGISTER <= r[7:0];
         TEST_PORT_PINS_IN <= r[14:8];
         PROBE_BUS <= r[23:16];
         SELF_TEST_CMD <= r[24];
         xfer(1, TPSR_ADDR_PIN_LEVEL, d);
         xfer(0, TPSR_ADDR_PIN_LEVEL, 0);
         `CHK("pin_level", d[7] ? {1'b1, r[13:8], 1'b0} : d & 8'hfe, q)
         `CHK("pins_oe", d[7] ? {1'b0, r[6:1]} : 7'h0, TEST_PORT_PINS_OE)
         `CHK("pins_out", d[7:1], TEST_PORT_PINS_OUT)
         xfer(1, TPSR_ADDR_PROBE_BUS, d);
         xfer(1, TPSR_ADDR_VERSION, d);
         xfer(0, TPSR_ADDR_PROBE_BUS, 0);
         `CHK("probe_bus", r[23:16], q)
         xfer(0, TPSR_ADDR_VERSION, 0);
         `CHK("version", TPSR_VERSION_CODE, q)
         xfer(0, 10'h3fc, 0);
         `CHK("unmapped", 8'h00, q)
         xfer(1, TPSR_ADDR_SELF_CHECK, s);
         xfer(0, TPSR_ADDR_SELF_CHECK, 0);
         `CHK("self_check", s & 8'h4f, q)
         `CHK("nonlinear", s[6], RECEIVER_NONLINEAR)
         `CHK("st_enabled", s[3:0] == 4'h9, SELF_TEST_ENABLED)
         `CHK("st_run", r[24] && s[3:0] == 4'h9, SELF_TEST_RUN)
      end
      // host leaves self test with the disabling code before normal use
      xfer(1, TPSR_ADDR_SELF_CHECK, 8'h40);
      xfer(0, TPSR_ADDR_SELF_CHECK, 0);
      `CHK("self_check_off", 8'h40, q)
      `CHK("st_disabled", 1'b0, SELF_TEST_ENABLED)
      test_done();
   end
endmodule
`default_nettype wire
